// >>> src/dcsc_capture.sv
// capture end: samples the strobe clock, lanes and sync into the input buffer
`timescale 1ns/1ns
module dcsc_capture
  import dcsc_pkg::*;
#(
  parameter int W     = SAMPLE_W,
  parameter int DEPTH = CAPT_DEPTH
) (
  input  wire logic               clk,
  input  wire logic               srst,
  input  wire logic               dual_mode,
  input  wire logic [$clog2(DEPTH)-1:0] rd_index,
  output logic      [2*W-1:0]     rd_data,
  output logic      [W-1:0]       capt_a,
  output logic      [W-1:0]       capt_b,
  output logic                    capt_valid,
  output logic                    capt_sync,
  output logic [$clog2(DEPTH)-1:0] wr_ptr,
  dcsc_link_if.capture            link
);
  localparam int AW = $clog2(DEPTH);

  logic         clk_s1;
  logic         clk_s2;
  logic         clk_d;
  logic [W-1:0] lane_s1;
  logic [W-1:0] lane_s2;
  logic         sync_s1;
  logic         sync_s2;
  logic         rise;
  logic         fall;
  logic [W-1:0] pend_a;
  logic         pend_sync;
  logic [AW-1:0] base;
  logic [2*W-1:0] mem [DEPTH];

  // lanes share the clock's two stages so they stay aligned with its edges
  always_ff @(posedge clk) begin
    if (srst) begin
      clk_s1  <= 1'b0;
      clk_s2  <= 1'b0;
      clk_d   <= 1'b0;
      lane_s1 <= '0;
      lane_s2 <= '0;
      sync_s1 <= 1'b0;
      sync_s2 <= 1'b0;
    end else begin
      clk_s1  <= link.sample_strobe_clock;
      clk_s2  <= clk_s1;
      clk_d   <= clk_s2;
      lane_s1 <= link.sample_lane;
      lane_s2 <= lane_s1;
      sync_s1 <= link.sync_strobe;
      sync_s2 <= sync_s1;
    end
  end

  assign rise = clk_s2 && !clk_d;
  assign fall = !clk_s2 && clk_d;
  // write slot: zero when the pending rise carried sync
  assign base = pend_sync ? '0 : wr_ptr;

  always_ff @(posedge clk) begin
    if (srst) begin
      pend_a    <= '0;
      pend_sync <= 1'b0;
    end else if (rise) begin
      pend_a    <= lane_s2;
      pend_sync <= sync_s2;
    end
  end

  // write on rise in single mode, on the following fall in dual mode
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr     <= AW'(PTR_RESET);
      capt_a     <= '0;
      capt_b     <= '0;
      capt_valid <= 1'b0;
      capt_sync  <= 1'b0;
    end else begin
      capt_valid <= 1'b0;
      if (!dual_mode && rise) begin
        mem[sync_s2 ? '0 : wr_ptr] <= {lane_s2, {W{1'b0}}};
        wr_ptr     <= sync_s2 ? AW'(1) : wr_ptr + 1'b1;
        capt_a     <= lane_s2;
        capt_b     <= '0;
        capt_valid <= 1'b1;
        capt_sync  <= sync_s2;
      end else if (dual_mode && fall) begin
        mem[base]  <= {pend_a, lane_s2};
        wr_ptr     <= base + 1'b1;
        capt_a     <= pend_a;
        capt_b     <= lane_s2;
        capt_valid <= 1'b1;
        capt_sync  <= pend_sync;
      end
    end
  end

  // buffer contents are not reset; the pointer and the rd_data read register are
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_index];
    end
  end
endmodule

// >>> src/dcsc_pkg.sv
// shared constants for the dual channel sample capture link
package dcsc_pkg;
  localparam int CLK_PERIOD_NS  = 40;
  localparam int LINK_PERIOD_NS = 320;
  localparam int LINK_HALF_CYC  = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int SAMPLE_W       = 12;
  localparam int SRC_FIFO_DEPTH = 4;
  localparam int CAPT_DEPTH     = 8;
  localparam bit MODE_RESET     = 1'b1;
  localparam bit LINK_CLK_RESET = 1'b0;
  localparam bit SYNC_RESET     = 1'b0;
  localparam int PTR_RESET      = 0;
endpackage

// >>> src/dcsc_link_if.sv
// link between sample source and capture end
`timescale 1ns/1ns
interface dcsc_link_if #(parameter int W = 12);
  logic         sample_strobe_clock;
  logic [W-1:0] sample_lane;
  logic         sync_strobe;
  modport source (output sample_strobe_clock, output sample_lane, output sync_strobe);
  modport capture (input sample_strobe_clock, input sample_lane, input sync_strobe);
endinterface

// >>> src/dcsc_fifo.sv
// small flop fifo with valid and ready on both sides
`timescale 1ns/1ns
module dcsc_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_idx;
  logic [AW-1:0]    rd_idx;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign out_valid = (count != '0);
  assign out_data  = mem[rd_idx];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  // ready is registered so the source's port comes from a flop
  always_ff @(posedge clk) begin
    if (srst) begin
      in_ready <= 1'b1;
    end else begin
      in_ready <= (next_count != (AW+1)'(DEPTH));
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_idx] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_idx <= '0;
      rd_idx <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_idx <= (wr_idx == AW'(DEPTH - 1)) ? '0 : wr_idx + 1'b1;
      end
      if (pop) begin
        rd_idx <= (rd_idx == AW'(DEPTH - 1)) ? '0 : rd_idx + 1'b1;
      end
      count <= next_count;
    end
  end
endmodule

// >>> src/dcsc_source.sv
// sample source end: makes the strobe clock and drives lanes and sync
`timescale 1ns/1ns
module dcsc_source
  import dcsc_pkg::*;
#(
  parameter int W     = SAMPLE_W,
  parameter int DEPTH = SRC_FIFO_DEPTH,
  parameter int HALF  = LINK_HALF_CYC
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         dual_mode,
  input  wire logic [W-1:0] in_a,
  input  wire logic [W-1:0] in_b,
  input  wire logic         in_sync,
  input  wire logic         in_valid,
  output logic              in_ready,
  dcsc_link_if.source       link
);
  localparam int PW   = $clog2(2 * HALF) + 1;
  localparam int FW   = 2 * W + 1;
  // one phase early: the lane flops add a cycle before the pins move
  localparam int A_PH = HALF + HALF / 2 - 1;
  localparam int B_PH = HALF / 2 - 1;
  localparam int LAST = 2 * HALF - 1;

  logic [PW-1:0] phase;
  logic [PW-1:0] next_phase;
  logic [FW-1:0] head;
  logic          head_valid;
  logic          take;
  logic [W-1:0]  held_b;
  logic          mode;
  logic          fifo_ready;
  logic          out_ready_q;

  assign next_phase = (phase == PW'(2 * HALF - 1)) ? '0 : phase + 1'b1;
  assign take       = (phase == PW'(A_PH)) && head_valid;
  assign in_ready   = fifo_ready;

  dcsc_fifo #(.WIDTH(FW), .DEPTH(DEPTH)) u_fifo (
    .clk       (clk),
    .srst      (srst),
    .in_data   ({in_sync, in_a, in_b}),
    .in_valid  (in_valid),
    .in_ready  (fifo_ready),
    .out_data  (head),
    .out_valid (head_valid),
    .out_ready (take)
  );

  // clock divider; rising edge when phase wraps to zero
  // reset parks on the last phase so the first high half is full length
  always_ff @(posedge clk) begin
    if (srst) begin
      phase                    <= PW'(LAST);
      link.sample_strobe_clock <= LINK_CLK_RESET;
    end else begin
      phase                    <= next_phase;
      link.sample_strobe_clock <= (next_phase < PW'(HALF));
    end
  end

  // mode only changes at a frame boundary
  always_ff @(posedge clk) begin
    if (srst) begin
      mode <= MODE_RESET;
    end else if (phase == PW'(A_PH)) begin
      mode <= dual_mode;
    end
  end

  // lanes change a quarter period before the edge that samples them
  always_ff @(posedge clk) begin
    if (srst) begin
      link.sample_lane <= '0;
      link.sync_strobe <= SYNC_RESET;
      held_b           <= '0;
    end else if (phase == PW'(A_PH)) begin
      if (head_valid) begin
        link.sample_lane <= head[2*W-1:W];
        link.sync_strobe <= head[FW-1];
        held_b           <= head[W-1:0];
      end else begin
        link.sync_strobe <= 1'b0;
      end
    end else if (phase == PW'(B_PH) && mode) begin
      link.sample_lane <= held_b;
      link.sync_strobe <= 1'b0;
    end else if (phase == PW'(B_PH)) begin
      link.sync_strobe <= 1'b0;
    end
  end
endmodule

// >>> bench/dcsc_link_asserts.sv
// wire level checks on the sample link
`timescale 1ns/1ns
module dcsc_link_asserts #(parameter int W = 12) (
  input wire logic         clk,
  input wire logic         srst,
  input wire logic         sample_strobe_clock,
  input wire logic [W-1:0] sample_lane,
  input wire logic         sync_strobe
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_high; sample_strobe_clock [*4]; endsequence
  sequence s_low; !sample_strobe_clock [*4]; endsequence
  AST_CLK_SHAPE: assert property ($rose(sample_strobe_clock) |-> s_high ##1 s_low)
    else $error("link clock phase length wrong");
  AST_SYNC_FALL: assert property ($fell(sample_strobe_clock) |-> !sync_strobe)
    else $error("sync high at falling edge");
  AST_SYNC_LEAD: assert property ($rose(sync_strobe) |->
    !sample_strobe_clock ##2 ($rose(sample_strobe_clock) && sync_strobe))
    else $error("sync not held into rising edge");
  // lanes move mid phase so both edges see settled data
  AST_LANE_MID: assert property ($changed(sample_lane) |->
    $stable(sample_strobe_clock) ##1 $stable(sample_strobe_clock))
    else $error("lanes change next to a clock edge");
  AST_LANE_FALL: assert property ($fell(sample_strobe_clock) |->
    $stable(sample_lane) ##1 $stable(sample_lane))
    else $error("lanes unstable at falling edge");
endmodule

// >>> bench/dcsc_tb.sv
// end to end bench for the sample capture link
`timescale 1ns/1ns
module dcsc_tb;
  logic        clk = 0, srst = 1, dual_mode = 0, in_sync = 0, in_valid = 0, take = 0;
  logic        started = 0, in_ready, capt_valid, capt_sync;
  logic [11:0] in_a = 0, in_b = 0, capt_a, capt_b;
  logic [2:0]  rd_index = 0, exp_ptr = 0, slot, wr_ptr;
  logic [23:0] rd_data;
  logic [24:0] q[$], last, e;
  int          n_fail = 0, check_count = 0, ncap = 0, k, m, seed = 32'h6e3fad6d;

  dcsc_link_if #(.W(12)) u_link ();
  dcsc_source u_dcsc_source (.clk(clk), .srst(srst), .dual_mode(dual_mode), .in_a(in_a),
    .in_b(in_b), .in_sync(in_sync), .in_valid(in_valid), .in_ready(in_ready), .link(u_link));
  dcsc_capture u_dcsc_capture (.clk(clk), .srst(srst), .dual_mode(dual_mode),
    .rd_index(rd_index), .rd_data(rd_data), .capt_a(capt_a), .capt_b(capt_b),
    .capt_valid(capt_valid), .capt_sync(capt_sync), .wr_ptr(wr_ptr), .link(u_link));
  dcsc_link_asserts #(.W(12)) u_asserts (.clk(clk), .srst(srst),
    .sample_strobe_clock(u_link.sample_strobe_clock), .sample_lane(u_link.sample_lane),
    .sync_strobe(u_link.sync_strobe));

  initial forever #20 clk = ~clk;

  task automatic chk_d(string nm, logic [23:0] ex, logic [23:0] got);
    check_count++;
    if (got !== ex) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic chk_p(string nm, logic [3:0] ex, logic [3:0] got);
    check_count++;
    if (got !== ex) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // single mode drops the falling edge word
  function automatic logic [24:0] expect_word(logic [24:0] w, logic d);
    return d ? w : {w[24:12], 12'h000};
  endfunction

  // leading zero captures before the first word are skipped
  always @(negedge clk) begin
    if (!srst && capt_valid === 1'b1 && (started || capt_a !== 12'h000)) begin
      started = 1;
      // empty source fifo: lanes keep their last value, sync low
      if (q.size()) begin
        e = q.pop_front();
      end else begin
        e = dual_mode ? {1'b0, last[11:0], last[11:0]} : {1'b0, last[23:0]};
      end
      last = e;
      e = expect_word(e, dual_mode);
      chk_d("capture", e[23:0], {capt_a, capt_b});
      chk_p("sync", {3'h0, e[24]}, {3'h0, capt_sync});
      slot = e[24] ? 3'h0 : exp_ptr;
      exp_ptr = slot + 3'h1;
      chk_p("wr_ptr", {1'b0, exp_ptr}, {1'b0, wr_ptr});
      rd_index <= slot;
      ncap++;
      @(negedge clk);
      @(negedge clk);
      chk_d("buffer", e[23:0], rd_data);
    end
  end

  initial begin
    for (m = 0; m < 2; m++) begin
      srst = 1;
      started = 0;
      dual_mode = m[0];
      in_valid = 0;
      q.delete();
      last = 0;
      ncap = 0;
      repeat (10) @(negedge clk);
      srst = 0;
      @(negedge clk);
      {in_sync, in_a, in_b} = 25'h1FFF000;
      in_valid = 1;
      take = in_ready;
      k = 0;
      for (int t = 0; k < 12 && t < 500; t++) begin
        @(negedge clk);
        if (in_valid && take) begin
          q.push_back({in_sync, in_a, in_b});
          k++;
          in_sync = ($random(seed) & 7) == 0;
          in_a = $random(seed);
          in_b = (k == 1) ? 12'hFFF : $random(seed);
        end
        // a refused word stays offered until the source takes it
        if (!in_valid || take) begin
          in_valid = (($random(seed) & 3) != 0) && k < 12;
        end
        take = in_ready;
      end
      if (k < 12) begin
        n_fail++;
        wrap_up();
      end
      for (k = 0; k < 400 && ncap < 15; k++) @(negedge clk);
      if (ncap < 15) begin
        n_fail++;
        wrap_up();
      end
      // let the pending buffer read finish before the next reset
      repeat (4) @(negedge clk);
    end
    wrap_up();
  end
endmodule
